//--- hdl/cmbs_map.svh
`ifndef CMBS_MAP_SVH
`define CMBS_MAP_SVH
// buffer select nibble values (address bits 7:4 of the 8-bit offset into the block)
`define CMBS_SEL_RX_BACK 4'h3
`define CMBS_SEL_RX_FORE 4'h4
`define CMBS_SEL_TX_FIRST 4'h5
`define CMBS_SEL_TX_LAST 4'h7
// byte offsets inside one 16-byte buffer window
`define CMBS_OFS_IDENT0 4'h0
`define CMBS_OFS_IDENT1 4'h1
`define CMBS_OFS_IDENT3 4'h3
`define CMBS_OFS_PAYLOAD0 4'h4
`define CMBS_OFS_PAYLOAD7 4'hB
`define CMBS_OFS_LENGTH 4'hC
`define CMBS_OFS_PRIORITY 4'hD
// field positions
`define CMBS_BIT_SRR 4
`define CMBS_BIT_FMT 3
`define CMBS_BIT_STD_RTR 4
`define CMBS_BIT_EXT_RTR 0
// largest data byte count
`define CMBS_MAX_BYTES 4'h8
// value of unused locations and of fields without storage
`define CMBS_READ_ZERO 8'h00
`endif

//--- hdl/cmbs_pkg.sv
package cmbs_pkg;
  typedef logic [7:0] cmbs_byte_t;
  // one 13-byte message structure plus priority
  typedef struct packed {
    cmbs_byte_t [3:0] ident;
    cmbs_byte_t [7:0] payload;
    cmbs_byte_t length;
    cmbs_byte_t prio;
  } cmbs_buf_s;
  // cpu access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    cmbs_byte_t wdata;
  } cmbs_cpu_s;
  // received frame handed over by the bus engine
  typedef struct packed {
    logic valid;
    cmbs_byte_t [3:0] ident;
    cmbs_byte_t [7:0] payload;
    cmbs_byte_t length;
  } cmbs_rx_s;
  typedef enum logic [2:0] {
    CMBS_IDLE = 3'b001,
    CMBS_SELECT = 3'b010,
    CMBS_SEND = 3'b100
  } cmbs_state_e;
  // frame offered to the bus engine
  typedef struct packed {
    logic valid;
    logic [1:0] index;
    logic extended;
    logic [28:0] ident;
    logic remote;
    logic [3:0] length;
    logic [3:0] nbytes;
    cmbs_byte_t [7:0] payload;
  } cmbs_tx_s;
endpackage

//--- hdl/cmbs_store.sv
`timescale 1ns/1ns
`include "cmbs_map.svh"
//////////////////////////////////////////////////////////////////////////////
// How it works
// - each buffer fills a 16-byte window
// - offsets: ident 0-3, data 4-11, length 12, prio 13
// - nibble 4 receive, 5-7 transmit zero..two
// - message bytes not reset, unknown until written
// - receive buffer readable, cpu writes ignored
// - transmit buffers readable and writable anytime
// - extended identifier byte layout
// - standard identifier layout, format flag zero
// - 11 or 29 bit identifiers, msb first
// - smaller identifier wins bus arbitration
// - software sets substitute bit; received stored as seen
// - format flag selects standard or extended
// - length code binary 0..8 byte count
// - remote frame sends length, zero data bytes
// - only length-code many data bytes used
// - priority byte only on transmit buffers
// - non-empty transmit buffers compete before start
// - smallest local priority value wins
// - equal priority: lowest index wins
// - background receive buffer readable in test only
module cmbs_store #(
  parameter int NUM_TX = 3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // cpu side
  input cmbs_pkg::cmbs_cpu_s cpu,
  input wire logic testMode,
  output cmbs_pkg::cmbs_byte_t cpuRdata,
  output logic cpuRvalid,
  // transmit-empty flags, kept by the flag logic
  input wire logic [NUM_TX-1:0] txEmptyFlag,
  // bus engine side
  input wire logic sofReq,
  input wire logic txDone,
  input cmbs_pkg::cmbs_rx_s rxFrame,
  input wire logic rxToForeground,
  output cmbs_pkg::cmbs_tx_s txFrame
);

  typedef struct packed {
    cmbs_pkg::cmbs_buf_s [NUM_TX-1:0] tx;
    cmbs_pkg::cmbs_buf_s rx_foreground_buf;
    cmbs_pkg::cmbs_buf_s rx_background_buf;
    cmbs_pkg::cmbs_byte_t rdata;
    logic rvalid;
    cmbs_pkg::cmbs_state_e state;
    logic [NUM_TX-1:0] pending;
    cmbs_pkg::cmbs_tx_s txOut;
  } cmbs_state_s;

  cmbs_state_s s_q;
  cmbs_state_s s_d;
  logic [3:0] bufSel;
  logic [3:0] byteOfs;
  logic [1:0] winIdx;
  logic winFound;
  cmbs_pkg::cmbs_byte_t winPrio;
  logic [NUM_TX-1:0] better;
  cmbs_pkg::cmbs_buf_s selBuf;
  logic selExt;
  logic selRemote;
  logic [3:0] selLen;

  assign bufSel = cpu.addr[7:4];
  assign byteOfs = cpu.addr[3:0];

  //////////////////////////////////////////////////////////////////////////////
  // byte read out of one window; priority slot only where the buffer has one
  function automatic cmbs_pkg::cmbs_byte_t winRead(
    input cmbs_pkg::cmbs_buf_s b,
    input logic [3:0] ofs,
    input logic hasPrio
  );
    cmbs_pkg::cmbs_byte_t r;
    r = `CMBS_READ_ZERO;
    if (ofs <= `CMBS_OFS_IDENT3) begin
      r = b.ident[2'(ofs)];
    end else if (ofs <= `CMBS_OFS_PAYLOAD7) begin
      r = b.payload[3'(ofs - `CMBS_OFS_PAYLOAD0)];
    end else if (ofs == `CMBS_OFS_LENGTH) begin
      r = {4'h0, b.length[3:0]};
    end else if (ofs == `CMBS_OFS_PRIORITY && hasPrio) begin
      r = b.prio;
    end
    return r; // offsets 14 and 15 read zero
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // internal prioritisation: strict less-than keeps the lower index on a tie
  always_comb begin
    winFound = 1'b0;
    winIdx = 2'h0;
    winPrio = 8'hFF;
    for (int i = 0; i < NUM_TX; i++) begin
      better[i] = !txEmptyFlag[i] && (!winFound || s_q.tx[i].prio < winPrio);
      if (better[i]) begin
        winFound = 1'b1;
        winIdx = 2'(i);
        winPrio = s_q.tx[i].prio;
      end
    end
  end

  // decode the chosen buffer into an outgoing frame
  always_comb begin
    selBuf = s_q.tx[winIdx];
    selExt = selBuf.ident[1][`CMBS_BIT_FMT];
    selRemote = selExt ? selBuf.ident[3][`CMBS_BIT_EXT_RTR]
                       : selBuf.ident[1][`CMBS_BIT_STD_RTR];
    selLen = selBuf.length[3:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic for all storage, reads and the selection machine
  always_comb begin
    s_d = s_q;
    s_d.rvalid = cpu.rd;
    s_d.rdata = `CMBS_READ_ZERO;
    // cpu reads: receive buffer always, background only under
    if (cpu.rd) begin
      if (bufSel == `CMBS_SEL_RX_FORE) begin
        s_d.rdata = winRead(s_q.rx_foreground_buf, byteOfs, 1'b0);
      end else if (bufSel >= `CMBS_SEL_TX_FIRST && bufSel <= `CMBS_SEL_TX_LAST) begin
        s_d.rdata = winRead(s_q.tx[2'(bufSel - `CMBS_SEL_TX_FIRST)], byteOfs, 1'b1);
      end else if (testMode && bufSel == `CMBS_SEL_RX_BACK) begin
        s_d.rdata = winRead(s_q.rx_background_buf, byteOfs, 1'b0);
      end
    end
    // cpu writes reach transmit buffers only; no mode gating
    if (cpu.wr && bufSel >= `CMBS_SEL_TX_FIRST && bufSel <= `CMBS_SEL_TX_LAST) begin
      for (int i = 0; i < NUM_TX; i++) begin
        if (2'(bufSel - `CMBS_SEL_TX_FIRST) == 2'(i)) begin
          if (byteOfs <= `CMBS_OFS_IDENT3) begin
            s_d.tx[i].ident[2'(byteOfs)] = cpu.wdata;
          end else if (byteOfs <= `CMBS_OFS_PAYLOAD7) begin
            s_d.tx[i].payload[3'(byteOfs - `CMBS_OFS_PAYLOAD0)] = cpu.wdata;
          end else if (byteOfs == `CMBS_OFS_LENGTH) begin
            s_d.tx[i].length = {4'h0, cpu.wdata[3:0]};
          end else if (byteOfs == `CMBS_OFS_PRIORITY) begin
            s_d.tx[i].prio = cpu.wdata;
          end
        end
      end
    end
    // received frame lands in background, then copied to foreground
    if (rxFrame.valid) begin
      s_d.rx_background_buf.ident = rxFrame.ident; // substitute bit kept as seen
      s_d.rx_background_buf.length = {4'h0, rxFrame.length[3:0]};
      for (int k = 0; k < 8; k++) begin
        if (4'(k) < rxFrame.length[3:0]) begin
          s_d.rx_background_buf.payload[k] = rxFrame.payload[k];
        end
      end
    end
    if (rxToForeground) begin
      s_d.rx_foreground_buf = s_q.rx_background_buf;
    end
    // selection machine: choose right before start of frame
    case (s_q.state)
      cmbs_pkg::CMBS_IDLE: begin
        if (sofReq) begin
          s_d.state = cmbs_pkg::CMBS_SELECT;
        end
      end
      cmbs_pkg::CMBS_SELECT: begin
        s_d.pending = ~txEmptyFlag;
        if (winFound) begin
          s_d.txOut.valid = 1'b1;
          s_d.txOut.index = winIdx;
          s_d.txOut.extended = selExt;
          // msb-first order is kept by placing the id in bits 28 down, or in bits 10 down for a standard id
          s_d.txOut.ident = selExt
            ? {selBuf.ident[0], selBuf.ident[1][7:5], selBuf.ident[1][2:0],
               selBuf.ident[2], selBuf.ident[3][7:1]}
            : {18'h0, selBuf.ident[0], selBuf.ident[1][7:5]};
          s_d.txOut.remote = selRemote;
          s_d.txOut.length = selLen;
          s_d.txOut.nbytes = selRemote ? 4'h0
            : (selLen > `CMBS_MAX_BYTES ? `CMBS_MAX_BYTES : selLen);
          s_d.txOut.payload = selBuf.payload;
          s_d.state = cmbs_pkg::CMBS_SEND;
        end else begin
          s_d.state = cmbs_pkg::CMBS_IDLE;
        end
      end
      cmbs_pkg::CMBS_SEND: begin
        if (txDone) begin
          s_d.txOut.valid = 1'b0;
          s_d.state = cmbs_pkg::CMBS_IDLE;
        end
      end
      default: begin
        s_d.state = cmbs_pkg::CMBS_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // register stage; message storage deliberately left out of reset
  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
    if (srst) begin
      s_q.rdata <= 8'h00;
      s_q.rvalid <= 1'b0;
      s_q.state <= cmbs_pkg::CMBS_IDLE;
      s_q.pending <= '0;
      s_q.txOut <= '0;
    end
  end

  assign cpuRdata = s_q.rdata;
  assign cpuRvalid = s_q.rvalid;
  assign txFrame = s_q.txOut;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_rx_nowrite;
    @(posedge ref_clk) disable iff (srst)
      (cpu.wr && bufSel == `CMBS_SEL_RX_FORE && !rxToForeground) |=> $stable(s_q.rx_foreground_buf);
  endproperty
  a_rx_nowrite: assert property (p_rx_nowrite) else $error("receive buffer changed by cpu write");

  property p_tx_write;
    @(posedge ref_clk) disable iff (srst)
      (cpu.wr && bufSel == `CMBS_SEL_TX_FIRST && byteOfs == `CMBS_OFS_PRIORITY)
        |=> s_q.tx[0].prio == $past(cpu.wdata);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("priority write lost");

  property p_rd_lat;
    @(posedge ref_clk) disable iff (srst) cpu.rd |=> cpuRvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");

  property p_unused;
    @(posedge ref_clk) disable iff (srst)
      (cpu.rd && byteOfs > `CMBS_OFS_PRIORITY) |=> cpuRdata == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused byte not zero");

  property p_rx_noprio;
    @(posedge ref_clk) disable iff (srst)
      (cpu.rd && bufSel == `CMBS_SEL_RX_FORE && byteOfs == `CMBS_OFS_PRIORITY)
        |=> cpuRdata == 8'h00;
  endproperty
  a_rx_noprio: assert property (p_rx_noprio) else $error("receive priority slot");

  property p_winner_pending;
    @(posedge ref_clk) disable iff (srst)
      $rose(txFrame.valid) |-> s_q.pending[txFrame.index];
  endproperty
  a_winner_pending: assert property (p_winner_pending) else $error("empty buffer chosen");

  property p_winner_min;
    @(posedge ref_clk) disable iff (srst)
      (s_q.state == cmbs_pkg::CMBS_SELECT && winFound) |->
        (txEmptyFlag[0] || s_q.tx[0].prio > winPrio || winIdx == 2'h0);
  endproperty
  a_winner_min: assert property (p_winner_min) else $error("priority or tie order wrong");

  property p_remote_zero;
    @(posedge ref_clk) disable iff (srst)
      (txFrame.valid && txFrame.remote) |-> txFrame.nbytes == 4'h0;
  endproperty
  a_remote_zero: assert property (p_remote_zero) else $error("remote frame with data");

  property p_nbytes;
    @(posedge ref_clk) disable iff (srst)
      txFrame.valid |-> txFrame.nbytes <= `CMBS_MAX_BYTES;
  endproperty
  a_nbytes: assert property (p_nbytes) else $error("byte count over eight");

  property p_std_id;
    @(posedge ref_clk) disable iff (srst)
      (txFrame.valid && !txFrame.extended) |-> txFrame.ident[28:11] == 18'h0;
  endproperty
  a_std_id: assert property (p_std_id) else $error("standard id too wide");

  property p_rx_ident;
    @(posedge ref_clk) disable iff (srst)
      rxFrame.valid |=> s_q.rx_background_buf.ident == $past(rxFrame.ident);
  endproperty
  a_rx_ident: assert property (p_rx_ident) else $error("rx id altered");

  property p_rx_len;
    @(posedge ref_clk) disable iff (srst)
      rxFrame.valid |=> s_q.rx_background_buf.length == {4'h0, $past(rxFrame.length[3:0])};
  endproperty
  a_rx_len: assert property (p_rx_len) else $error("rx length altered");

  property p_fg_copy;
    @(posedge ref_clk) disable iff (srst)
      rxToForeground |=> s_q.rx_foreground_buf.ident == $past(s_q.rx_background_buf.ident);
  endproperty
  a_fg_copy: assert property (p_fg_copy) else $error("foreground copy lost");

  // nibbles outside the map, and the hidden background buffer, read zero
  property p_unmapped;
    @(posedge ref_clk) disable iff (srst)
      (cpu.rd && (bufSel < `CMBS_SEL_RX_FORE || bufSel > `CMBS_SEL_TX_LAST)
        && !(testMode && bufSel == `CMBS_SEL_RX_BACK)) |=> cpuRdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_len_hi;
    @(posedge ref_clk) disable iff (srst)
      (cpu.rd && byteOfs == `CMBS_OFS_LENGTH) |=> cpuRdata[7:4] == 4'h0;
  endproperty
  a_len_hi: assert property (p_len_hi) else $error("length upper bits set");

  property p_none_pending;
    @(posedge ref_clk) disable iff (srst)
      (s_q.state == cmbs_pkg::CMBS_SELECT && &txEmptyFlag) |=> !txFrame.valid;
  endproperty
  a_none_pending: assert property (p_none_pending) else $error("sent from empty set");

  // the offered frame stands untouched until the engine ends it
  property p_frame_holds;
    @(posedge ref_clk) disable iff (srst)
      (s_q.state == cmbs_pkg::CMBS_SEND && !txDone)
        |=> (s_q.state == cmbs_pkg::CMBS_SEND && $stable(txFrame));
  endproperty
  a_frame_holds: assert property (p_frame_holds) else $error("frame changed while sent");

  // every losing pending buffer ranks no better than the winner
  for (genvar p = 0; p < NUM_TX * NUM_TX; p++) begin : g_order
    localparam int WIN = p / NUM_TX;
    localparam int LOSE = p % NUM_TX;
    property p_win_order;
      @(posedge ref_clk) disable iff (srst)
        ($rose(txFrame.valid) && txFrame.index == 2'(WIN) && !$past(txEmptyFlag[LOSE]))
          |-> ($past(s_q.tx[WIN].prio) < $past(s_q.tx[LOSE].prio))
            || ($past(s_q.tx[WIN].prio) == $past(s_q.tx[LOSE].prio) && WIN <= LOSE);
    endproperty
    a_win_order: assert property (p_win_order) else $error("outranked buffer won");
  end

endmodule

//--- tb/cmbs_bus_node.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// far side: bus engine and remote nodes, driven through tasks
module cmbs_bus_node (
  // clock
  input wire logic ref_clk,
  // store side
  input cmbs_pkg::cmbs_tx_s txFrame,
  output logic sofReq,
  output logic txDone,
  output cmbs_pkg::cmbs_rx_s rxFrame,
  output logic rxToForeground
);
  // quiet lines from time zero
  initial begin
    sofReq = 1'b0;
    txDone = 1'b0;
    rxToForeground = 1'b0;
    rxFrame = '0;
  end
  // one start of frame, then the frame is held for a chosen span
  task automatic transmit(input int hold, output cmbs_pkg::cmbs_tx_s seen);
    int n = 0;
    @(posedge ref_clk) #1 sofReq = 1'b1;
    @(posedge ref_clk) #1 sofReq = 1'b0;
    while (txFrame.valid !== 1'b1 && n < 4) begin
      @(posedge ref_clk) #1 n++;
    end
    seen = txFrame;
    if (seen.valid === 1'b1) begin
      repeat (hold) @(posedge ref_clk);
      #1 txDone = 1'b1;
      @(posedge ref_clk) #1 txDone = 1'b0;
    end
  endtask
  // frame as seen on the wire, then released lines toggle so stale data shows
  task automatic receive(input cmbs_pkg::cmbs_rx_s f);
    @(posedge ref_clk) #1 rxFrame = f;
    @(posedge ref_clk) #1 rxFrame = {1'b0, ~f[$bits(f)-2:0]};
    rxToForeground = 1'b1;
    @(posedge ref_clk) #1 rxToForeground = 1'b0;
  endtask
endmodule

//--- tb/tb_can_message_buffer_store.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module tb_can_message_buffer_store;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic testMode = 1'b0;
  logic [2:0] txEmptyFlag = 3'h7;
  cmbs_pkg::cmbs_cpu_s cpu = '0;
  cmbs_pkg::cmbs_byte_t cpuRdata;
  logic cpuRvalid, sofReq, txDone, rxToForeground;
  cmbs_pkg::cmbs_rx_s rxFrame, f;
  cmbs_pkg::cmbs_tx_s txFrame, seen;
  cmbs_pkg::cmbs_byte_t mem [3][16];
  int fails = 0;
  int num_checks = 0;
  int b;
  // store under test and its bus partner
  cmbs_store i_dut (.ref_clk(ref_clk), .srst(srst), .cpu(cpu), .testMode(testMode),
    .cpuRdata(cpuRdata), .cpuRvalid(cpuRvalid), .txEmptyFlag(txEmptyFlag),
    .sofReq(sofReq), .txDone(txDone), .rxFrame(rxFrame),
    .rxToForeground(rxToForeground), .txFrame(txFrame));
  cmbs_bus_node i_node (.ref_clk(ref_clk), .txFrame(txFrame), .sofReq(sofReq),
    .txDone(txDone), .rxFrame(rxFrame), .rxToForeground(rxToForeground));
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////////
  // compare and verdict
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // single-byte cpu cycles; the model mirrors transmit writes only
  task automatic wr(input logic [7:0] a, input cmbs_pkg::cmbs_byte_t d);
    @(posedge ref_clk) #1 cpu = '{1'b0, 1'b1, a, d};
    @(posedge ref_clk) #1 cpu.wr = 1'b0;
    if (a[7:4] > 4'h4) mem[a[7:4] - 4'h5][a[3:0]] = d;
  endtask
  task automatic rdchk(input logic [7:0] a, input cmbs_pkg::cmbs_byte_t e);
    @(posedge ref_clk) #1 cpu = '{1'b1, 1'b0, a, 8'($urandom)};
    @(posedge ref_clk) #1 cpu.rd = 1'b0;
    chk(cpuRvalid, 1'b1);
    chk(cpuRdata, e);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // random buffer bytes; few priority values so that ties are frequent
  function automatic cmbs_pkg::cmbs_byte_t rnd(input logic [3:0] o, input int r);
    rnd = 8'($urandom);
    if (o == 4'h1 && rnd[3]) rnd[4] = 1'b1;
    if (o == 4'hC) rnd[3:0] = 4'($urandom_range(9));
    if (o == 4'hD) rnd = r == 0 ? 8'h40 : 8'($urandom_range(3) * 8'h55);
  endfunction
  function automatic cmbs_pkg::cmbs_byte_t txExp(input logic [7:0] a);
    if (a[3:0] > 4'hD) return 8'h00;
    return mem[a[7:4] - 4'h5][a[3:0]] & (a[3:0] == 4'hC ? 8'h0F : 8'hFF);
  endfunction
  function automatic cmbs_pkg::cmbs_byte_t rxExp(input int o);
    if (o < 4) return f.ident[o];
    if (o < 12) return f.payload[o - 4];
    return o == 12 ? f.length : 8'h00;
  endfunction
  // strict less-than keeps the lower index on a tie
  function automatic int pick(input logic [2:0] empty);
    int w = -1;
    for (int i = 0; i < 3; i++)
      if (!empty[i] && (w < 0 || mem[i][13] < mem[w][13])) w = i;
    return w;
  endfunction
  // fields of the offered frame against the winning buffer
  task automatic txchk(input int k);
    logic ext, rem;
    logic [3:0] nb;
    ext = mem[k][1][3];
    rem = ext ? mem[k][3][0] : mem[k][1][4];
    nb = rem ? 4'h0 : mem[k][12][3:0] > 4'h8 ? 4'h8 : mem[k][12][3:0];
    chk(seen.index, k[1:0]);
    chk(seen.extended, ext);
    chk(seen.remote, rem);
    chk(seen.length, mem[k][12][3:0]);
    chk(seen.nbytes, nb);
    if (ext) chk(seen.ident, {mem[k][0], mem[k][1][7:5], mem[k][1][2:0],
      mem[k][2], mem[k][3][7:1]});
    else chk(seen.ident[10:0], {mem[k][0], mem[k][1][7:5]});
    for (int i = 0; i < nb; i++) chk(seen.payload[i], mem[k][4 + i]);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h5d17));
    repeat (3) @(posedge ref_clk);
    #1 srst = 1'b0;
    for (int r = 0; r < 24; r++) begin
      // receive path; bytes past the length stay unknown, so they are skipped
      f.valid = 1'b1;
      f.ident = $urandom;
      f.payload = {$urandom, $urandom};
      f.length = 8'($urandom_range(8));
      i_node.receive(f);
      for (int o = 0; o < 16; o++)
        if (o < 4 || o > 11 || o - 4 < f.length) rdchk(8'h40 + 8'(o), rxExp(o));
      wr(8'h40, ~f.ident[0]);
      rdchk(8'h40, f.ident[0]);
      rdchk(8'h30, 8'h00);
      testMode = 1'b1;
      rdchk(8'h30, f.ident[0]);
      testMode = 1'b0;
      rdchk(8'h20, 8'h00);
      // transmit buffers: fill, read back, then one arbitration round
      for (int a = 8'h50; a < 8'h80; a++)
        if (a[3:0] < 4'hE) wr(8'(a), rnd(a[3:0], r));
      for (int a = 8'h50; a < 8'h80; a++)
        rdchk(8'(a), txExp(8'(a)));
      txEmptyFlag = r == 0 ? 3'h0 : r == 1 ? 3'h7 : 3'($urandom);
      i_node.transmit($urandom_range(3), seen);
      b = pick(txEmptyFlag);
      chk(seen.valid, b >= 0);
      if (b >= 0) txchk(b);
    end
    report_and_stop();
  end
  // watchdog: a full run needs well under 10000 cycles
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule
